// [hdl/clk_sel_pkg.sv]
// Purpose: Shared constants and types for the sample clock reference selector
// Assumes: 25 MHz system clock
// Notes:   Rates are carried in Hz as unsigned integers
package clk_sel_pkg;

  typedef enum logic [1:0]
  {
    SRC_INTERNAL = 2'b00,
    SRC_MADI     = 2'b01,
    SRC_WORD     = 2'b10,
    SRC_AES      = 2'b11
  } clk_src_t;

  typedef enum logic [1:0]
  {
    MODE_AUTO     = 2'b00,
    MODE_MASTER   = 2'b01,
    MODE_INTERNAL = 2'b10
  } clk_mode_t;

  typedef enum logic [1:0]
  {
    LOCK_NONE = 2'b00,
    LOCK_LOCK = 2'b01,
    LOCK_SYNC = 2'b10
  } lock_state_t;

  typedef enum logic [2:0]
  {
    PRE_NONE    = 3'b000,
    PRE_UP_0P1  = 3'b001,
    PRE_DN_0P1  = 3'b010,
    PRE_UP_4    = 3'b011,
    PRE_DN_4    = 3'b100
  } preset_t;

  localparam int RATE_W           = 18;
  localparam int OFS_W            = 14;
  localparam logic [RATE_W-1:0] RST_BASE_RATE = 18'h0ac44;
  localparam logic [OFS_W-1:0]  RST_OFFSET    = 14'h0000;
  localparam logic [OFS_W-1:0]  FINE_STEP_HZ  = 14'h0001;
  localparam logic [OFS_W-1:0]  COARSE_STEP_HZ = 14'h0032;
  localparam int PCT_RANGE        = 5;
  localparam int PRE_SMALL_PERMIL = 1;
  localparam int PRE_LARGE_PERMIL = 40;
  localparam int SWITCH_GAP_CYC   = 2;
  localparam int NUM_INPUTS       = 3;
  localparam int IDX_MADI         = 0;
  localparam int IDX_WORD         = 1;
  localparam int IDX_AES          = 2;

endpackage : clk_sel_pkg

// [hdl/sample_clock_reference_selector.sv]
// Purpose: Sample clock reference selection, status and internal rate synthesis
// Assumes: Input lock/rate detection is done upstream and sampled on i_clk
// Notes:   Clock changeover gates the enable for a short gap before switching
// Notes on behaviour
// R1: Auto mode follows first valid input clock
// R2: Loss of reference reverts to internal master
// R3: Preferred input first, others scanned in turn
// R4: No valid input means master mode
// R5: Per input report none, lock or sync
// R6: Report current clock source
// R7: Internal mode never switches to inputs
// R8: Slave keeps external rate, host rate ignored
// R9: Report detected rate, flag mismatch
// R10: Fine offset 1 Hz, limited to 5%
// R11: Coarse offset steps of 50 Hz
// R12: Presets 0.1% and 4% up/down
// R13: Offset applies only in master mode
// R14: Offset disabled on USB attachment
// R15: System has exactly one clock master
// R16: Report MADI frame and channel format
// R17: Glitch-free reference changeover
// R18: Offset zero after reset
module sample_clock_reference_selector
  import clk_sel_pkg::*;
#(
  parameter int N_IN = NUM_INPUTS
)
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic [1:0]        i_mode,
  input  wire logic [1:0]        i_pref_src,
  input  wire logic [RATE_W-1:0] i_host_rate,
  input  wire logic              i_usb_attached,
  input  wire logic              i_fine_up,
  input  wire logic              i_fine_dn,
  input  wire logic              i_coarse_up,
  input  wire logic              i_coarse_dn,
  input  wire logic              i_ofs_reset,
  input  wire logic [2:0]        i_preset,
  input  wire logic [N_IN-1:0]   i_in_valid,
  input  wire logic [N_IN-1:0]   i_in_sync,
  input  wire logic [RATE_W-1:0] i_rate_madi,
  input  wire logic [RATE_W-1:0] i_rate_word,
  input  wire logic [RATE_W-1:0] i_rate_aes,
  input  wire logic              i_madi_96k_frame,
  input  wire logic              i_madi_56ch,
  output logic [1:0]             o_cur_src,
  output logic                   o_master,
  output logic                   o_clk_gate,
  output logic [1:0]             o_lock_madi,
  output logic [1:0]             o_lock_word,
  output logic [1:0]             o_lock_aes,
  output logic [RATE_W-1:0]      o_eff_rate,
  output logic [RATE_W-1:0]      o_det_rate,
  output logic                   o_rate_err,
  output logic signed [OFS_W-1:0] o_offset,
  output logic                   o_madi_96k_frame,
  output logic                   o_madi_56ch
);

  ////////////////////////////////////////////////////////////////////////////
  // Source choice
  logic [1:0] cur_src_ff;
  logic [1:0] tgt_src_ff;
  logic [1:0] gap_ff;
  logic signed [OFS_W-1:0] ofs_ff;

  function automatic logic src_ok(input logic [1:0] s, input logic [N_IN-1:0] v);
    logic r;
    r = 1'b0;
    case (s)
      SRC_MADI: r = v[IDX_MADI];
      SRC_WORD: r = v[IDX_WORD];
      SRC_AES:  r = v[IDX_AES];
      default:  r = 1'b0;
    endcase
    return r;
  endfunction : src_ok

  wire logic       is_auto   = (i_mode == MODE_AUTO);
  wire logic       pref_ok   = src_ok(i_pref_src, i_in_valid);
  wire logic [1:0] scan_src  = i_in_valid[IDX_MADI] ? SRC_MADI :
                               i_in_valid[IDX_WORD] ? SRC_WORD :
                               i_in_valid[IDX_AES]  ? SRC_AES  : SRC_INTERNAL; // [R3]
  wire logic [1:0] want_src  = !is_auto ? SRC_INTERNAL :        // [R7]
                               pref_ok  ? i_pref_src   :        // [R3]
                               scan_src;                        // [R1] [R2] [R4]

  // Changeover: hold the gate low for a few cycles, then move to the new source
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cur_src_ff <= SRC_INTERNAL;
      tgt_src_ff <= SRC_INTERNAL;
      gap_ff     <= 2'h0;
      o_clk_gate <= 1'b1;
    end
    else if (i_ce)
    begin
      if (want_src != tgt_src_ff)
      begin
        tgt_src_ff <= want_src;
        gap_ff     <= 2'(SWITCH_GAP_CYC);
        o_clk_gate <= 1'b0;                                     // [R17]
      end
      else if (gap_ff != 2'h0)
      begin
        gap_ff <= gap_ff - 2'h1;
        if (gap_ff == 2'h1)
          cur_src_ff <= tgt_src_ff;
      end
      else
        o_clk_gate <= 1'b1;                                     // [R17]
    end
  end

  assign o_cur_src = cur_src_ff;                                // [R6]
  wire logic nxt_master = (cur_src_ff == SRC_INTERNAL);

  ////////////////////////////////////////////////////////////////////////////
  // Pitch offset
  wire logic signed [OFS_W-1:0] lim =
    OFS_W'((i_host_rate * PCT_RANGE) / 100);                    // [R10]
  wire logic signed [OFS_W-1:0] pre_small =
    OFS_W'((i_host_rate * PRE_SMALL_PERMIL) / 1000);
  wire logic signed [OFS_W-1:0] pre_large =
    OFS_W'((i_host_rate * PRE_LARGE_PERMIL) / 1000);
  wire logic pitch_en = !i_usb_attached;                        // [R14]
  wire logic signed [OFS_W-1:0] step =
    i_coarse_up ?  $signed(COARSE_STEP_HZ) :                    // [R11]
    i_coarse_dn ? -$signed(COARSE_STEP_HZ) :
    i_fine_up   ?  $signed(FINE_STEP_HZ)   :                    // [R10]
    i_fine_dn   ? -$signed(FINE_STEP_HZ)   : '0;
  wire logic signed [OFS_W:0] sum = ofs_ff + step;
  wire logic signed [OFS_W-1:0] sum_clip =
    (sum > lim)  ? lim  :
    (sum < -lim) ? -lim : OFS_W'(sum);                          // [R10]
  wire logic signed [OFS_W-1:0] nxt_ofs =
    !pitch_en                      ? RST_OFFSET :               // [R14]
    i_ofs_reset                    ? RST_OFFSET :
    (i_preset == PRE_UP_0P1)       ? pre_small  :               // [R12]
    (i_preset == PRE_DN_0P1)       ? -pre_small :
    (i_preset == PRE_UP_4)         ? pre_large  :
    (i_preset == PRE_DN_4)         ? -pre_large :
    sum_clip;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ofs_ff <= RST_OFFSET;                                     // [R18]
    else if (i_ce)
      ofs_ff <= nxt_ofs;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rates and status
  wire logic [RATE_W-1:0] ext_rate =
    (cur_src_ff == SRC_MADI) ? i_rate_madi :
    (cur_src_ff == SRC_WORD) ? i_rate_word :
    (cur_src_ff == SRC_AES)  ? i_rate_aes  : '0;
  wire logic [RATE_W-1:0] int_rate =
    RATE_W'($signed({1'b0, i_host_rate}) + ofs_ff);             // [R13]
  wire logic [RATE_W-1:0] nxt_eff_rate =
    nxt_master ? int_rate : ext_rate;                           // [R8] [R13]
  wire logic [RATE_W-1:0] nxt_det_rate =
    i_in_sync[IDX_WORD] ? i_rate_word :
    i_in_sync[IDX_MADI] ? i_rate_madi :
    i_in_sync[IDX_AES]  ? i_rate_aes  : '0;
  wire logic nxt_rate_err = (|i_in_sync) && (nxt_det_rate != i_host_rate); // [R9]

  function automatic logic [1:0] lock_of(input logic v, input logic s);
    return !v ? LOCK_NONE : (s ? LOCK_SYNC : LOCK_LOCK);
  endfunction : lock_of

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_master         <= 1'b1;
      o_eff_rate       <= RST_BASE_RATE;
      o_det_rate       <= '0;
      o_rate_err       <= 1'b0;
      o_lock_madi      <= LOCK_NONE;
      o_lock_word      <= LOCK_NONE;
      o_lock_aes       <= LOCK_NONE;
      o_offset         <= RST_OFFSET;
      o_madi_96k_frame <= 1'b0;
      o_madi_56ch      <= 1'b0;
    end
    else if (i_ce)
    begin
      o_master         <= nxt_master;                                    // [R2] [R4]
      o_eff_rate       <= nxt_eff_rate;
      o_det_rate       <= nxt_det_rate;                                  // [R9]
      o_rate_err       <= nxt_rate_err;                                  // [R9]
      o_lock_madi      <= lock_of(i_in_valid[IDX_MADI], i_in_sync[IDX_MADI]); // [R5]
      o_lock_word      <= lock_of(i_in_valid[IDX_WORD], i_in_sync[IDX_WORD]); // [R5]
      o_lock_aes       <= lock_of(i_in_valid[IDX_AES], i_in_sync[IDX_AES]);   // [R5]
      o_offset         <= ofs_ff;
      o_madi_96k_frame <= i_in_valid[IDX_MADI] & i_madi_96k_frame;       // [R16]
      o_madi_56ch      <= i_in_valid[IDX_MADI] & i_madi_56ch;            // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_internal_stays;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_mode == MODE_INTERNAL) |=> ##3 (!i_ce || cur_src_ff == SRC_INTERNAL
        || i_mode != MODE_INTERNAL || $past(i_mode) != MODE_INTERNAL);
  endproperty
  a_internal_stays: assert property (p_internal_stays) else $error("left internal clock"); // [R7]

  property p_pref_taken;
    @(posedge i_clk) disable iff (i_sys_rst)
      (is_auto && pref_ok && i_pref_src != SRC_INTERNAL) |-> (want_src == i_pref_src);
  endproperty
  a_pref_taken: assert property (p_pref_taken) else $error("preferred input not chosen"); // [R3]

  property p_none_master;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_in_valid == '0) |-> (want_src == SRC_INTERNAL);
  endproperty
  a_none_master: assert property (p_none_master) else $error("no input but not master"); // [R4]

  property p_gate_low_on_change;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && $changed(cur_src_ff)) |-> !o_clk_gate;
  endproperty
  a_gate_low_on_change: assert property (p_gate_low_on_change) else $error("ungated switch"); // [R17]

  property p_ofs_limit;
    @(posedge i_clk) disable iff (i_sys_rst)
      (ofs_ff <= lim) && (ofs_ff >= -lim || lim == '0);
  endproperty
  a_ofs_limit: assert property (p_ofs_limit) else $error("offset out of range"); // [R10]

  property p_usb_no_pitch;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_usb_attached) |=> (ofs_ff == '0);
  endproperty
  a_usb_no_pitch: assert property (p_usb_no_pitch) else $error("pitch on usb"); // [R14]

  property p_coarse_step;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && pitch_en && !i_ofs_reset && i_preset == PRE_NONE && i_coarse_up
       && sum <= lim) |=> (ofs_ff == $past(ofs_ff) + $signed(COARSE_STEP_HZ));
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("coarse step wrong"); // [R11]

  property p_slave_rate;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !nxt_master) |=> (o_eff_rate == $past(ext_rate) && !o_master);
  endproperty
  a_slave_rate: assert property (p_slave_rate) else $error("slave rate modified"); // [R8]

  property p_rate_err;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && |i_in_sync && nxt_det_rate != i_host_rate) |=> o_rate_err;
  endproperty
  a_rate_err: assert property (p_rate_err) else $error("rate mismatch not flagged"); // [R9]

  property p_lock_sync;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_in_valid[IDX_WORD] && i_in_sync[IDX_WORD])
        |=> (o_lock_word == LOCK_SYNC);
  endproperty
  a_lock_sync: assert property (p_lock_sync) else $error("word sync not reported"); // [R5]

  property p_lock_none;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !i_in_valid[IDX_AES]) |=> (o_lock_aes == LOCK_NONE);
  endproperty
  a_lock_none: assert property (p_lock_none) else $error("absent input shows lock"); // [R5]

  property p_madi_fmt_gated;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && !i_in_valid[IDX_MADI]) |=> (!o_madi_96k_frame && !o_madi_56ch);
  endproperty
  a_madi_fmt_gated: assert property (p_madi_fmt_gated) else $error("format without input"); // [R16]

  property p_master_flag;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_ce |=> (o_master == ($past(cur_src_ff) == SRC_INTERNAL));
  endproperty
  a_master_flag: assert property (p_master_flag) else $error("master flag wrong"); // [R4]

  property p_gate_gap;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && want_src != tgt_src_ff) |=> (!o_clk_gate) [*3];
  endproperty
  a_gate_gap: assert property (p_gate_gap) else $error("gate opened during gap"); // [R17]

  property p_master_rate;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && nxt_master) |=> (o_eff_rate == $past(int_rate));
  endproperty
  a_master_rate: assert property (p_master_rate) else $error("master rate wrong"); // [R13]

  property p_preset_small;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && pitch_en && !i_ofs_reset && i_preset == PRE_UP_0P1)
        |=> (ofs_ff == $past(pre_small));
  endproperty
  a_preset_small: assert property (p_preset_small) else $error("small preset wrong"); // [R12]

  property p_no_sync_no_err;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && i_in_sync == '0) |=> (o_det_rate == '0 && !o_rate_err);
  endproperty
  a_no_sync_no_err: assert property (p_no_sync_no_err) else $error("error without sync"); // [R9]

  property p_reset_ofs;
    @(posedge i_clk) disable iff (i_sys_rst)
      $fell(i_sys_rst) |-> (ofs_ff == RST_OFFSET && o_offset == RST_OFFSET);
  endproperty
  a_reset_ofs: assert property (p_reset_ofs) else $error("offset not zero after reset"); // [R18]

endmodule : sample_clock_reference_selector

// [tb/ext_clock_sources.sv]
// Purpose: External audio gear that feeds the selector its clock references
// Assumes: Shared rate for every present input
// Notes:   Absent inputs report rate zero and no format
module ext_clock_sources
  import clk_sel_pkg::*;
(
  input  wire logic [NUM_INPUTS-1:0] i_present,
  input  wire logic [NUM_INPUTS-1:0] i_aligned,
  input  wire logic [RATE_W-1:0]     i_rate,
  input  wire logic                  i_f96,
  input  wire logic                  i_c56,
  output logic [NUM_INPUTS-1:0]      o_valid,
  output logic [NUM_INPUTS-1:0]      o_sync,
  output logic [RATE_W-1:0]          o_rate_madi,
  output logic [RATE_W-1:0]          o_rate_word,
  output logic [RATE_W-1:0]          o_rate_aes,
  output logic                       o_f96,
  output logic                       o_c56
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gear runs as slave, aligned only when locked to our master clock
  assign o_valid     = i_present;
  assign o_sync      = i_present & i_aligned;
  assign o_rate_madi = i_present[IDX_MADI] ? i_rate : '0;
  assign o_rate_word = i_present[IDX_WORD] ? i_rate : '0;
  assign o_rate_aes  = i_present[IDX_AES] ? i_rate : '0;
  assign o_f96       = i_present[IDX_MADI] & i_f96;
  assign o_c56       = i_present[IDX_MADI] & i_c56;
endmodule : ext_clock_sources

// [tb/sample_clock_reference_selector_tb.sv]
// Purpose: Self-checking bench for the sample clock reference selector
// Assumes: Host rate 44100 Hz unless a scenario changes it
// Notes:   Inputs change 1 ns after the rising edge
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module sample_clock_reference_selector_tb;
  import clk_sel_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_sys_rst = 1, usb = 0, cu = 0, cd = 0, fu = 0, fd = 0, orst = 0, ce = 1;
  logic [1:0] mode = 2'h0, pref = 2'h0;
  logic [2:0] preset = 3'h0, pres = 3'h0, algn = 3'h0, vld, syn;
  logic [RATE_W-1:0] host = 18'h0ac44, rate = 18'h0bb80, rm, rw, ra, eff, det;
  logic f96 = 0, c56 = 0, m96, m56, master, gate, err, seen_low;
  logic m96_o, m56_o;
  logic [1:0] src, lm, lw, la;
  logic signed [OFS_W-1:0] ofs;
  int n_fail = 0, comparisons = 0;
  initial forever #20 i_clk = ~i_clk;
  ext_clock_sources src_model (.i_present(pres), .i_aligned(algn), .i_rate(rate),
    .i_f96(f96), .i_c56(c56), .o_valid(vld), .o_sync(syn), .o_rate_madi(rm),
    .o_rate_word(rw), .o_rate_aes(ra), .o_f96(m96), .o_c56(m56));
  sample_clock_reference_selector DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce),
    .i_mode(mode), .i_pref_src(pref), .i_host_rate(host), .i_usb_attached(usb),
    .i_fine_up(fu), .i_fine_dn(fd), .i_coarse_up(cu), .i_coarse_dn(cd), .i_ofs_reset(orst),
    .i_preset(preset), .i_in_valid(vld), .i_in_sync(syn), .i_rate_madi(rm),
    .i_rate_word(rw), .i_rate_aes(ra), .i_madi_96k_frame(m96), .i_madi_56ch(m56),
    .o_cur_src(src), .o_master(master), .o_clk_gate(gate), .o_lock_madi(lm),
    .o_lock_word(lw), .o_lock_aes(la), .o_eff_rate(eff), .o_det_rate(det),
    .o_rate_err(err), .o_offset(ofs), .o_madi_96k_frame(m96_o), .o_madi_56ch(m56_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  // Waits bounded for a source change, noting whether the gate closed
  task automatic wait_src(input logic [1:0] exp);
    seen_low = 0;
    for (int i = 0; i < 20 && src !== exp; i++)
    begin
      step(1);
      if (gate === 1'b0) seen_low = 1;
    end
    if (src !== exp)
    begin
      n_fail++;
      $display("unexpected src expected %0h seen %0h", exp, src);
      report_and_stop();
    end
    else
      step(2);
  endtask : wait_src
  task automatic pulse(input logic [4:0] p);
    {cu, cd, fu, fd, orst} = p;
    step(1);
    {cu, cd, fu, fd, orst} = 5'h00;
    step(1);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_auto;
    pres = 3'h2;
    wait_src(SRC_WORD);
    `CHK("gate_closed", 1'b1, seen_low)
    `CHK("gate", 1'b1, gate)
    `CHK("master", 1'b0, master)
    `CHK("eff_rate", 18'h0bb80, eff)
    `CHK("lock_word", LOCK_LOCK, lw)
    `CHK("lock_madi", LOCK_NONE, lm)
    host = 18'h17700;
    step(3);
    `CHK("slave_rate", 18'h0bb80, eff)
    host = 18'h0ac44;
    pref = 2'h3;
    pres = 3'h7;
    wait_src(SRC_AES);
    pres = 3'h3;
    wait_src(SRC_MADI);
    pres = 3'h0;
    wait_src(SRC_INTERNAL);
    `CHK("master_loss", 1'b1, master)
    `CHK("eff_loss", 18'h0ac44, eff)
  endtask : t_auto
  task automatic t_internal;
    pres = 3'h7;
    wait_src(SRC_AES);
    mode = 2'h2;
    wait_src(SRC_INTERNAL);
    step(6);
    `CHK("int_src", SRC_INTERNAL, src)
    `CHK("int_master", 1'b1, master)
    `CHK("lock_aes", LOCK_LOCK, la)
    `CHK("int_eff", 18'h0ac44, eff)
  endtask : t_internal
  task automatic t_sync;
    mode = 2'h1;
    pres = 3'h3;
    algn = 3'h2;
    rate = 18'h07d00;
    f96 = 1;
    c56 = 1;
    step(3);
    `CHK("sync_word", LOCK_SYNC, lw)
    `CHK("lock_madi_on", LOCK_LOCK, lm)
    `CHK("lock_aes_off", LOCK_NONE, la)
    `CHK("det_rate", 18'h07d00, det)
    `CHK("rate_err", 1'b1, err)
    `CHK("frame96", 1'b1, m96_o)
    `CHK("ch56", 1'b1, m56_o)
    rate = 18'h0ac44;
    step(3);
    `CHK("rate_ok", 1'b0, err)
    pres = 3'h0;
    algn = 3'h0;
  endtask : t_sync
  task automatic t_pitch;
    pulse(5'h04);
    `CHK("fine", 14'h0001, ofs)
    pulse(5'h10);
    `CHK("coarse", 14'h0033, ofs)
    `CHK("eff_ofs", 18'h0ac77, eff)
    pulse(5'h08);
    pulse(5'h02);
    `CHK("back_zero", 14'h0000, ofs)
    cu = 1;
    step(45);
    cu = 0;
    step(1);
    `CHK("clip", 14'h089d, ofs)
    ce = 0;
    cd = 1;
    step(3);
    cd = 0;
    ce = 1;
    step(1);
    `CHK("frozen", 14'h089d, ofs)
    pulse(5'h01);
    `CHK("ofs_rst", 14'h0000, ofs)
    preset = 3'h1;
    step(2);
    `CHK("up01", 14'h002c, ofs)
    preset = 3'h2;
    step(2);
    `CHK("dn01", 14'h3fd4, ofs)
    preset = 3'h3;
    step(2);
    `CHK("up4", 14'h06e4, ofs)
    preset = 3'h4;
    step(2);
    `CHK("dn4", 14'h391c, ofs)
    preset = 3'h3;
    usb = 1;
    step(2);
    `CHK("usb", 14'h0000, ofs)
    usb = 0;
    mode = 2'h0;
    pres = 3'h2;
    wait_src(SRC_WORD);
    `CHK("slave_ofs", 18'h0ac44, eff)
    preset = 3'h0;
  endtask : t_pitch
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(3);
    i_sys_rst = 0;
    step(1);
    `CHK("rst_src", SRC_INTERNAL, src)
    `CHK("rst_master", 1'b1, master)
    `CHK("rst_ofs", 14'h0000, ofs)
    `CHK("rst_eff", 18'h0ac44, eff)
    t_auto();
    t_internal();
    t_sync();
    t_pitch();
    report_and_stop();
  end
endmodule : sample_clock_reference_selector_tb
